// ---- src/nvm_protect_map.sv ----
// Module: block protection range decode
module nvm_protect_map
(
    input  wire logic [15:0] addr,
    input  wire logic [4:0]  protect_select_field,
    input  wire logic        protect_open_bit,
    output logic             is_protected
);
    logic [15:0] base;
    always_comb
    begin
        // Base address moves down 1K per step below the top code
        base = 16'(({11'h000, protect_select_field} + 16'h0001) << nvm_seq_pkg::PROT_STEP_LSB)
               + nvm_seq_pkg::PROT_FULL_BASE;                                  // see R11 R12
        if (!protect_open_bit)
            is_protected = (addr >= nvm_seq_pkg::PROT_FULL_BASE);              // see R13
        else if (protect_select_field == nvm_seq_pkg::PROT_NONE)
            is_protected = 1'b0;                                               // see R11
        else
            is_protected = (addr >= base) && (addr <= nvm_seq_pkg::PROT_TOP_ADDR);
    end
endmodule : nvm_protect_map

// ---- src/nvm_seq_pkg.sv ----
// Package: constants for the nonvolatile memory command sequencer
//**********************************************************************
// Contract
// R01: Pump on for command, off after done
// R02: Keep pump on for queued same-block burst
// R03: Burst blocks are 64 aligned bytes
// R04: Abort command stops active sector erase
// R05: Software first writes any array address
// R06: Command code 0x47 decodes as abort
// R07: Writing one to buffer-empty launches command
// R08: Cut-short erase sets access error at completion
// R09: Normally finished erase leaves access error clear
// R10: Software re-erases sector after aborted erase
// R11: Select 0x1F none; each step 1K more
// R12: Select 0x00 protects 0x8400 through 0xFFFF
// R13: Open bit zero protects 0x8000 through 0xFFFF
// R14: Refuse protected program/erase, flag the refusal
//**********************************************************************
package nvm_seq_pkg;
    localparam int         ADDR_W          = 16;
    localparam int         BURST_BYTES     = 64;
    localparam int         BURST_LSB       = $clog2(BURST_BYTES);
    localparam logic [7:0] CMD_BLANK       = 8'h05;
    localparam logic [7:0] CMD_BYTE_PROG   = 8'h20;
    localparam logic [7:0] CMD_BURST_PROG  = 8'h25;
    localparam logic [7:0] CMD_SECT_ERASE  = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE  = 8'h41;
    localparam logic [7:0] CMD_ERASE_ABORT = 8'h47;
    localparam logic [4:0] PROT_NONE       = 5'h1F;
    localparam int         PROT_STEP_LSB   = 10;
    localparam logic [15:0] PROT_FULL_BASE = 16'h8000;
    localparam logic [15:0] PROT_TOP_ADDR  = 16'hFFFF;
    localparam logic [7:0] RST_CMD         = 8'h00;
    localparam int         PUMP_UP_NS      = 20;
    localparam int         PROG_NS         = 80;
    localparam int         BURST_NS        = 40;
    localparam int         ERASE_NS        = 400;
    localparam int         CLK_PERIOD_NS   = 4;
    localparam int         PUMP_UP_CYC     = (PUMP_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         PROG_CYC        = (PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         BURST_CYC       = (BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         ERASE_CYC       = (ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         CNT_W           = 16;
    typedef enum logic [2:0] {ST_IDLE, ST_PUMP_UP, ST_EXEC, ST_ABORT_WAIT} seq_state_e;
endpackage : nvm_seq_pkg

// ---- src/nvm_sequencer.sv ----
// Module: command sequencer with burst pump hold and erase abort
module nvm_sequencer
#(
    parameter int PUMP_UP_CYC = nvm_seq_pkg::PUMP_UP_CYC,
    parameter int PROG_CYC    = nvm_seq_pkg::PROG_CYC,
    parameter int BURST_CYC   = nvm_seq_pkg::BURST_CYC,
    parameter int ERASE_CYC   = nvm_seq_pkg::ERASE_CYC
)
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        array_wr,
    input  wire logic [15:0] array_wr_addr,
    input  wire logic [7:0]  array_wr_data,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_wr_data,
    input  wire logic        launch_w1c,
    input  wire logic        access_error_w1c,
    input  wire logic        protect_error_w1c,
    input  wire logic [4:0]  protect_select_field,
    input  wire logic        protect_open_bit,
    output logic             cmd_buffer_empty_flag,
    output logic             cmd_complete_flag,
    output logic             access_error_flag,
    output logic             protect_error_flag,
    output logic [7:0]       nvm_command_reg,
    output logic             pump_on,
    output logic             array_prog_pulse,
    output logic             array_erase_pulse,
    output logic [15:0]      op_addr,
    output logic [7:0]       op_data
);
    //******************************************************************
    // Command buffer
    //******************************************************************
    logic [15:0] buf_addr_ff;
    logic [7:0]  buf_data_ff;
    logic        buf_loaded_ff;
    logic        buf_full_ff;
    logic        buf_prot;
    logic        take;
    logic        is_abort;
    logic [15:0] cur_addr_ff;
    logic [7:0]  cur_data_ff;
    logic [7:0]  cur_cmd_ff;
    logic        cur_burst;
    logic        cur_erase;
    logic        same_block;
    logic        hold_pump;
    logic        abort_req_ff;
    logic        done;
    logic        erase_cut;
    logic        launch_ok;
    logic [nvm_seq_pkg::CNT_W-1:0] cnt_ff;
    nvm_seq_pkg::seq_state_e state_ff;

    //******************************************************************
    // Protection lookup
    //******************************************************************
    nvm_protect_map u_prot
    (
        .addr                 (buf_addr_ff),
        .protect_select_field (protect_select_field),
        .protect_open_bit     (protect_open_bit),
        .is_protected         (buf_prot)
    );

    //******************************************************************
    // Command decode
    //******************************************************************
    assign is_abort  = (nvm_command_reg == nvm_seq_pkg::CMD_ERASE_ABORT);     // see R06
    // Launch needs an empty buffer and a loaded array write, else it is ignored
    assign launch_ok = launch_w1c && !buf_full_ff && buf_loaded_ff;          // see R07
    assign cur_burst = (cur_cmd_ff == nvm_seq_pkg::CMD_BURST_PROG);
    assign cur_erase = (cur_cmd_ff == nvm_seq_pkg::CMD_SECT_ERASE)
                    || (cur_cmd_ff == nvm_seq_pkg::CMD_MASS_ERASE);
    assign same_block = (buf_addr_ff[15:nvm_seq_pkg::BURST_LSB]
                         == cur_addr_ff[15:nvm_seq_pkg::BURST_LSB]);          // see R03
    assign done = (state_ff == nvm_seq_pkg::ST_EXEC) && (cnt_ff == '0);
    // Queued unprotected burst into the same block keeps the pump; anything else drops it.
    // Spelled out in full: a continuous assignment does not follow
    // the module signals that a function reads.
    assign hold_pump = done && cur_burst && buf_full_ff
                    && (nvm_command_reg == nvm_seq_pkg::CMD_BURST_PROG)
                    && same_block
                    && !buf_prot;                                            // see R02 R03
    // Abort only cuts an erase that still has time left to run
    assign erase_cut = (state_ff == nvm_seq_pkg::ST_EXEC) && cur_erase
                    && abort_req_ff && (cnt_ff != '0);                       // see R04
    // Idle sequencer takes a launched command unless it is an abort or is refused
    assign take = (state_ff == nvm_seq_pkg::ST_IDLE) && buf_full_ff && !is_abort
               && !buf_prot;                                                // see R14

    // Buffer write takes the address and data whenever the buffer is empty, for any command, abort included
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            buf_addr_ff   <= 16'h0000;
            buf_data_ff   <= 8'h00;
            buf_loaded_ff <= 1'b0;
        end
        else if (array_wr && buf_empty_ok())
        begin
            buf_addr_ff   <= array_wr_addr;                                  // see R05
            buf_data_ff   <= array_wr_data;
            buf_loaded_ff <= 1'b1;
        end
        // Each launch needs a fresh array write
        else if (launch_ok)
            buf_loaded_ff <= 1'b0;
    end

    function automatic logic buf_empty_ok();
        buf_empty_ok = !buf_full_ff;
    endfunction : buf_empty_ok

    //******************************************************************
    // Command register
    //******************************************************************
    // Code is frozen while a launched command waits, so it cannot shift under it
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            nvm_command_reg <= nvm_seq_pkg::RST_CMD;
        else if (cmd_wr && !buf_full_ff)
            nvm_command_reg <= cmd_wr_data;
    end

    //******************************************************************
    // Launch
    //******************************************************************
    // Full means launched and waiting for the sequencer
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            buf_full_ff <= 1'b0;
        else if (launch_ok)
            buf_full_ff <= 1'b1;                                             // see R07
        else if (buf_full_ff && (is_abort || buf_prot
                 || (state_ff == nvm_seq_pkg::ST_IDLE)
                 || hold_pump_q()))
            buf_full_ff <= 1'b0;
    end

    function automatic logic hold_pump_q();
        hold_pump_q = done && cur_burst && (nvm_command_reg == nvm_seq_pkg::CMD_BURST_PROG)
                   && same_block;
    endfunction : hold_pump_q

    assign cmd_buffer_empty_flag = !buf_full_ff;

    //******************************************************************
    // Abort request
    //******************************************************************
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            abort_req_ff <= 1'b0;
        // An abort seen while idle has nothing to cut and is dropped
        else if (buf_full_ff && is_abort)
            abort_req_ff <= (state_ff != nvm_seq_pkg::ST_IDLE);              // see R04
        else if (state_ff == nvm_seq_pkg::ST_IDLE)
            abort_req_ff <= 1'b0;
    end

    //******************************************************************
    // Sequencer
    //******************************************************************
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_ff    <= nvm_seq_pkg::ST_IDLE;
            cnt_ff      <= '0;
            cur_addr_ff <= 16'h0000;
            cur_data_ff <= 8'h00;
            cur_cmd_ff  <= nvm_seq_pkg::RST_CMD;
        end
        else
        begin
            case (state_ff)
                nvm_seq_pkg::ST_IDLE:
                begin
                    // Refused commands never start: the buffer empties instead
                    if (buf_full_ff && take)
                    begin
                        cur_addr_ff <= buf_addr_ff;
                        cur_data_ff <= buf_data_ff;
                        cur_cmd_ff  <= nvm_command_reg;
                        cnt_ff      <= nvm_seq_pkg::CNT_W'(PUMP_UP_CYC - 1);
                        state_ff    <= nvm_seq_pkg::ST_PUMP_UP;                // see R01
                    end
                end
                nvm_seq_pkg::ST_PUMP_UP:
                begin
                    // Counts load N-1 so each phase lasts N cycles
                    if (cnt_ff == '0)
                    begin
                        state_ff <= nvm_seq_pkg::ST_EXEC;
                        if (cur_erase)
                            cnt_ff <= nvm_seq_pkg::CNT_W'(ERASE_CYC - 1);
                        else if (cur_burst)
                            cnt_ff <= nvm_seq_pkg::CNT_W'(BURST_CYC - 1);
                        else
                            cnt_ff <= nvm_seq_pkg::CNT_W'(PROG_CYC - 1);
                    end
                    else
                        cnt_ff <= cnt_ff - 1'b1;
                end
                nvm_seq_pkg::ST_EXEC:
                begin
                    // A cut erase commits nothing, so no erase strobe follows
                    if (erase_cut)
                        state_ff <= nvm_seq_pkg::ST_IDLE;                    // see R04 R08
                    else if (cnt_ff != '0)
                        cnt_ff <= cnt_ff - 1'b1;
                    else if (hold_pump)
                    begin
                        cur_addr_ff <= buf_addr_ff;                          // see R02
                        cur_data_ff <= buf_data_ff;
                        cnt_ff      <= nvm_seq_pkg::CNT_W'(BURST_CYC - 1);
                    end
                    else
                        state_ff <= nvm_seq_pkg::ST_IDLE;                    // see R01
                end
                default:
                    state_ff <= nvm_seq_pkg::ST_IDLE;
            endcase
        end
    end

    //******************************************************************
    // Charge pump
    //******************************************************************
    assign pump_on = (state_ff == nvm_seq_pkg::ST_PUMP_UP)
                  || (state_ff == nvm_seq_pkg::ST_EXEC);                     // see R01

    //******************************************************************
    // Array strobes
    //******************************************************************
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            array_prog_pulse  <= 1'b0;
            array_erase_pulse <= 1'b0;
            op_addr           <= 16'h0000;
            op_data           <= 8'h00;
        end
        else
        begin
            // Commit only on full completion; a cut erase writes nothing final
            array_prog_pulse  <= done && !cur_erase && (cur_cmd_ff != nvm_seq_pkg::CMD_BLANK);
            array_erase_pulse <= done && cur_erase;
            // Address and data lag one cycle so they line up with the strobe
            op_addr           <= cur_addr_ff;
            op_data           <= cur_data_ff;
        end
    end

    //******************************************************************
    // Status flags: hardware set beats software clear
    //******************************************************************
    logic complete_set;
    // A command still queued at the end keeps complete low across the gap
    assign complete_set = (done && !buf_full_ff) || erase_cut;               // see R08

    // Launch clears before the idle refresh, or a launch from idle never shows
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            cmd_complete_flag <= 1'b1;
        else if (complete_set)
            cmd_complete_flag <= 1'b1;                                       // see R01
        else if (launch_ok)
            cmd_complete_flag <= 1'b0;                                       // see R07
        else if ((state_ff == nvm_seq_pkg::ST_IDLE) && !buf_full_ff)
            cmd_complete_flag <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            access_error_flag <= 1'b0;
        // Sets with complete in the cut cycle; a normal finish leaves it clear
        else if (erase_cut)
            access_error_flag <= 1'b1;                                       // see R08
        else if (access_error_w1c)
            access_error_flag <= 1'b0;                                       // see R09
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            protect_error_flag <= 1'b0;
        // Blank check only reads, so a protected target is no error
        else if (buf_full_ff && buf_prot && !is_abort
                 && (nvm_command_reg != nvm_seq_pkg::CMD_BLANK))
            protect_error_flag <= 1'b1;                                      // see R14
        else if (protect_error_w1c)
            protect_error_flag <= 1'b0;
    end
endmodule : nvm_sequencer

// ---- verif/nvm_seq_monitor.sv ----
// Checker: port-level properties of the command sequencer
module nvm_seq_monitor
(
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       cmd_wr,
    input wire logic [7:0] cmd_wr_data,
    input wire logic       launch_w1c,
    input wire logic       access_error_w1c,
    input wire logic       cmd_buffer_empty_flag,
    input wire logic       cmd_complete_flag,
    input wire logic       access_error_flag,
    input wire logic       protect_error_flag,
    input wire logic [7:0] nvm_command_reg,
    input wire logic       pump_on,
    input wire logic       array_prog_pulse
);
    //******************************************************************
    // Properties
    //******************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_pump_rise_busy: assert property ($rose(pump_on) |-> !cmd_complete_flag)
        else $error("pump rose while idle");
    a_prog_under_pump: assert property (array_prog_pulse |-> $past(pump_on))
        else $error("program pulse without pump");
    a_prog_pulse_one: assert property (array_prog_pulse |=> !array_prog_pulse)
        else $error("program pulse longer than one cycle");
    a_cmd_load_code: assert property (cmd_wr && cmd_buffer_empty_flag |=>
        nvm_command_reg == $past(cmd_wr_data)) else $error("command not loaded");
    a_done_fall_launch: assert property ($fell(cmd_complete_flag) |->
        ($past(launch_w1c) || $past(launch_w1c, 2))) else $error("busy without launch");
    a_err_with_done: assert property ($rose(access_error_flag) |->
        $rose(cmd_complete_flag)) else $error("error not set at completion");
    a_err_abort_code: assert property ($rose(access_error_flag) |->
        nvm_command_reg == nvm_seq_pkg::CMD_ERASE_ABORT) else $error("error without abort");
    a_err_pump_off: assert property ($rose(access_error_flag) |-> !pump_on)
        else $error("pump still on after abort");
    a_err_clear_idle: assert property (access_error_flag && access_error_w1c &&
        cmd_complete_flag |=> !access_error_flag) else $error("error flag not cleared");
    a_prot_no_pump: assert property ($rose(protect_error_flag) |-> !pump_on)
        else $error("pump on for refused command");
    c_abort_err: cover property ($rose(access_error_flag));
    c_prot_err: cover property ($rose(protect_error_flag));
    c_prog_done: cover property (array_prog_pulse);
endmodule : nvm_seq_monitor

bind nvm_sequencer nvm_seq_monitor i_mon (.clock, .sys_rst, .cmd_wr, .cmd_wr_data,
    .launch_w1c, .access_error_w1c, .cmd_buffer_empty_flag, .cmd_complete_flag,
    .access_error_flag, .protect_error_flag, .nvm_command_reg, .pump_on, .array_prog_pulse);

// ---- verif/tb.sv ----
// Testbench: protection table, burst pump hold and erase abort
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [4:0] sel; logic opn; logic [15:0] addr; logic exp;} row_s;
    logic        clock, sys_rst, array_wr, cmd_wr, launch_w1c, access_error_w1c;
    logic        protect_error_w1c, protect_open_bit, cmd_buffer_empty_flag, pump_on;
    logic        cmd_complete_flag, access_error_flag, protect_error_flag;
    logic        array_prog_pulse, array_erase_pulse, pump_q;
    logic [15:0] array_wr_addr, op_addr, last_addr;
    logic [7:0]  array_wr_data, cmd_wr_data, nvm_command_reg, op_data, last_data;
    logic [4:0]  protect_select_field;
    int          err_total, comparisons, prog_n, erase_n, fall_n, p, e, f;
    row_s        rows[10] = '{'{5'h1F, 1, 16'hFFFF, 0}, '{5'h1E, 1, 16'hFC00, 1},
        '{5'h1E, 1, 16'hFBFF, 0}, '{5'h10, 1, 16'hC400, 1}, '{5'h10, 1, 16'hC3FF, 0},
        '{5'h00, 1, 16'h8400, 1}, '{5'h00, 1, 16'h83FF, 0}, '{5'h1F, 0, 16'h8000, 1},
        '{5'h1F, 0, 16'h7FFF, 0}, '{5'h1F, 0, 16'hFFFF, 1}};
    nvm_sequencer #(.PUMP_UP_CYC(5), .PROG_CYC(20), .BURST_CYC(10), .ERASE_CYC(100)) i_dut
        (.clock, .sys_rst, .array_wr, .array_wr_addr, .array_wr_data, .cmd_wr, .cmd_wr_data,
        .launch_w1c, .access_error_w1c, .protect_error_w1c, .protect_select_field,
        .protect_open_bit, .cmd_buffer_empty_flag, .cmd_complete_flag, .access_error_flag,
        .protect_error_flag, .nvm_command_reg, .pump_on, .array_prog_pulse,
        .array_erase_pulse, .op_addr, .op_data);
    //******************************************************************
    // Clock, observers and tasks
    //******************************************************************
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock)
    begin
        pump_q <= pump_on;
        if (array_prog_pulse === 1'b1)
        begin
            prog_n++;
            last_addr <= op_addr;
            last_data <= op_data;
        end
        if (array_erase_pulse === 1'b1) erase_n++;
        if (pump_q === 1'b1 && pump_on === 1'b0) fall_n++;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // Bounded wait for an empty buffer, and optionally for completion
    task automatic wait_ok(input bit idle);
        for (int n = 0; n < 3000; n++)
        begin
            if (cmd_buffer_empty_flag === 1'b1 && (!idle || cmd_complete_flag === 1'b1))
            begin
                // Strobe counters update one edge after complete rises
                if (idle) repeat (2) @(negedge clock);
                return;
            end
            @(negedge clock);
        end
        err_total++;
        print_verdict();
    endtask : wait_ok
    // Array write, command write, launch; only the launch must follow the array write
    task automatic issue(input logic [15:0] a, input logic [7:0] c);
        wait_ok(0);
        array_wr = 1'b1; array_wr_addr = a; array_wr_data = 8'hA5;
        @(negedge clock); array_wr = 1'b0; cmd_wr = 1'b1; cmd_wr_data = c;
        @(negedge clock); cmd_wr = 1'b0; launch_w1c = 1'b1;
        @(negedge clock); launch_w1c = 1'b0;
        repeat (3) @(negedge clock);
    endtask : issue
    //******************************************************************
    // Main sequence
    //******************************************************************
    initial
    begin
        {sys_rst, array_wr, cmd_wr, launch_w1c, access_error_w1c} = 5'h10;
        {protect_error_w1c, protect_open_bit, protect_select_field} = 7'h3F;
        {array_wr_addr, array_wr_data, cmd_wr_data} = 32'h0;
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        chk({cmd_buffer_empty_flag, cmd_complete_flag, access_error_flag}, 16'h6);
        chk({protect_error_flag, pump_on, nvm_command_reg}, 16'h0);
        foreach (rows[i])
        begin
            protect_select_field = rows[i].sel; protect_open_bit = rows[i].opn; p = prog_n;
            issue(rows[i].addr, nvm_seq_pkg::CMD_BYTE_PROG); wait_ok(1);
            chk(protect_error_flag, rows[i].exp);
            chk(prog_n - p, !rows[i].exp);
            if (!rows[i].exp) chk(last_addr, rows[i].addr);
            if (!rows[i].exp) chk(last_data, 16'h00A5);
            protect_error_w1c = 1'b1; @(negedge clock); protect_error_w1c = 1'b0;
        end
        protect_select_field = 5'h1F; protect_open_bit = 1'b1;
        // Queued burst inside one block keeps the pump up; across a boundary it drops
        f = fall_n; p = prog_n;
        issue(16'h1000, nvm_seq_pkg::CMD_BURST_PROG); issue(16'h1001, nvm_seq_pkg::CMD_BURST_PROG);
        wait_ok(1); chk(fall_n - f, 1); chk(prog_n - p, 2);
        f = fall_n;
        issue(16'h103F, nvm_seq_pkg::CMD_BURST_PROG); issue(16'h1040, nvm_seq_pkg::CMD_BURST_PROG);
        wait_ok(1); chk(fall_n - f, 2);
        // Abort in mid-erase, then an abort that arrives after the erase ended
        e = erase_n; issue(16'h4000, nvm_seq_pkg::CMD_SECT_ERASE); repeat (10) @(negedge clock);
        issue(16'h0123, nvm_seq_pkg::CMD_ERASE_ABORT); wait_ok(1);
        chk(nvm_command_reg, nvm_seq_pkg::CMD_ERASE_ABORT);
        chk({access_error_flag, pump_on}, 16'h2); chk(erase_n - e, 0);
        access_error_w1c = 1'b1; @(negedge clock); access_error_w1c = 1'b0; @(negedge clock);
        chk(access_error_flag, 0);
        issue(16'h4000, nvm_seq_pkg::CMD_SECT_ERASE); wait_ok(1);
        issue(16'hBEEF, nvm_seq_pkg::CMD_ERASE_ABORT); wait_ok(1);
        chk(access_error_flag, 0); chk(erase_n - e, 1);
        // Reset during the erase pump-up drops the pump and restores the idle flags
        issue(16'h2000, nvm_seq_pkg::CMD_SECT_ERASE);
        chk(pump_on, 1);
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        chk({cmd_buffer_empty_flag, cmd_complete_flag, access_error_flag, pump_on}, 16'hC);
        chk(nvm_command_reg, nvm_seq_pkg::RST_CMD);
        p = prog_n;
        issue(16'h2001, nvm_seq_pkg::CMD_BYTE_PROG);
        wait_ok(1);
        chk(prog_n - p, 1);
        chk(last_addr, 16'h2001);
        print_verdict();
    end
endmodule : tb
